// ---- shared/tmr_evt_pkg.sv ----
// package: modes, widths, reset values and carrier types of the timer event-flag block
package tmr_evt_pkg;

   localparam int CNT_W    = 16;
   localparam int NUM_CH   = 2;

   // channel modes
   typedef enum logic [2:0] {
      MODE_OFF     = 3'h0,
      MODE_CAPTURE = 3'h1,
      MODE_COMPARE = 3'h3,
      MODE_EDGE_ALIGNED_PWM    = 3'h2
   } chan_mode_t;

   // edge selection for capture
   typedef enum logic [1:0] {
      EDGE_NONE    = 2'h0,
      EDGE_RISING  = 2'h1,
      EDGE_FALLING = 2'h2,
      EDGE_BOTH    = 2'h3
   } edge_sel_t;

   // counter direction states, gray along up -> down
   typedef enum logic [1:0] {
      DIR_UP   = 2'h0,
      DIR_DOWN = 2'h1
   } cnt_dir_t;

   localparam logic [CNT_W-1:0] CNT_RESET  = 16'h0000;
   localparam logic [CNT_W-1:0] MOD_RESET  = 16'hFFFF;
   localparam logic             FLAG_RESET = 1'b0;

   // per-channel configuration carried as one word
   typedef struct packed {
      chan_mode_t             mode;
      edge_sel_t              channel_edge_select;
      logic [CNT_W-1:0]       value;
   } chan_cfg_t;

   // clear handshake from software side: read strobe and clear-write strobe
   typedef struct packed {
      logic status_read;
      logic flag_clear;
   } clr_req_t;

endpackage : tmr_evt_pkg

// ---- core/chan_event.sv ----
// one timer channel: capture edge detect, compare match, pwm events and its sticky flag
`timescale 1ns/1ps
module chan_event
(
   input  wire logic                         clk_i,
   input  wire logic                         reset_i,
   input  wire tmr_evt_pkg::chan_cfg_t       cfg_i,
   input  wire logic                         center_pwm_select_i,
   input  wire logic [tmr_evt_pkg::CNT_W-1:0] count_i,
   input  wire logic                         tick_i,
   input  wire logic                         pin_i,
   input  wire tmr_evt_pkg::clr_req_t        clr_i,
   output logic                              flag_o,
   output logic                              pin_oe_o
);

   logic pin_q;
   logic flag_q;
   logic armed_q;
   logic rise_w;
   logic fall_w;
   logic cap_hit_w;
   logic match_w;
   logic event_w;
   logic clear_ok_w;

   // edge detect against last sampled level
   assign rise_w  = pin_i & ~pin_q;
   assign fall_w  = ~pin_i & pin_q;
   assign cap_hit_w =
      (cfg_i.channel_edge_select == tmr_evt_pkg::EDGE_RISING  && rise_w) || // [RULE2]
      (cfg_i.channel_edge_select == tmr_evt_pkg::EDGE_FALLING && fall_w) ||
      (cfg_i.channel_edge_select == tmr_evt_pkg::EDGE_BOTH && (rise_w || fall_w));
   // a match is judged only on a counter tick so each count value fires once
   assign match_w = tick_i && (count_i == cfg_i.value);

   // in center mode every channel runs center_aligned_pwm; match fires up and down alike
   assign event_w = center_pwm_select_i ? match_w                          // [RULE6]
                  : (cfg_i.mode == tmr_evt_pkg::MODE_CAPTURE) ? cap_hit_w // [RULE3]
                  : (cfg_i.mode == tmr_evt_pkg::MODE_COMPARE) ? match_w   // [RULE4]
                  : (cfg_i.mode == tmr_evt_pkg::MODE_EDGE_ALIGNED_PWM)    ? match_w   // [RULE5]
                  : 1'b0;

   // clear only takes effect once a status read saw the flag set
   assign clear_ok_w = clr_i.flag_clear && armed_q;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         pin_q   <= 1'b0;
         flag_q  <= tmr_evt_pkg::FLAG_RESET;
         armed_q <= 1'b0;
      end
      else
      begin
         pin_q   <= pin_i;
         flag_q  <= event_w | (flag_q & ~clear_ok_w); // set wins over clear
         if (clr_i.flag_clear)
            armed_q <= 1'b0;
         else if (clr_i.status_read && flag_q)
            armed_q <= 1'b1;
      end
   end

   // pin released to port control until a compare or pwm function owns it
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         pin_oe_o <= 1'b0; // [RULE8]
      else
         pin_oe_o <= center_pwm_select_i || cfg_i.mode == tmr_evt_pkg::MODE_COMPARE ||
                     cfg_i.mode == tmr_evt_pkg::MODE_EDGE_ALIGNED_PWM;
   end

   assign flag_o = flag_q;

   capture_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE3]
      (!center_pwm_select_i && cfg_i.mode == tmr_evt_pkg::MODE_CAPTURE && cap_hit_w)
      |=> flag_q)
      else $error("capture edge did not set flag");

   compare_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE4]
      (!center_pwm_select_i && cfg_i.mode == tmr_evt_pkg::MODE_COMPARE && match_w)
      |=> flag_q)
      else $error("compare match did not set flag");

   edge_aligned_pwm_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE5]
      (!center_pwm_select_i && cfg_i.mode == tmr_evt_pkg::MODE_EDGE_ALIGNED_PWM && match_w) |=> flag_q)
      else $error("edge pwm match did not set flag");

   edge_none_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE2]
      (!center_pwm_select_i && cfg_i.mode == tmr_evt_pkg::MODE_CAPTURE &&
       cfg_i.channel_edge_select == tmr_evt_pkg::EDGE_NONE && !flag_q) |=> !flag_q)
      else $error("disabled capture set flag");

   blind_clear_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE9]
      (flag_q && clr_i.flag_clear && !armed_q) |=> flag_q)
      else $error("flag cleared without prior read");

   pin_idle_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE8]
      (!center_pwm_select_i && cfg_i.mode == tmr_evt_pkg::MODE_OFF) |=> !pin_oe_o)
      else $error("idle channel owns pin");

endmodule : chan_event

// ---- core/tmr_event_flags.sv ----
// timer event-flag block: counter with up or up/down mode, overflow flag and channel events
// Functional notes
// RULE1: center mode sets overflow flag at turnaround
// RULE2: edge select: off, rising, falling, both
// RULE3: selected capture edge sets channel flag
// RULE4: compare match sets channel flag
// RULE5: edge pwm match sets channel flag
// RULE6: center pwm flags both matches
// RULE7: center pwm counts up then down
// RULE8: no pin owned by timer after reset
// RULE9: clear needs prior status read
`timescale 1ns/1ps
module tmr_event_flags
#(
   parameter int NUM_CH = tmr_evt_pkg::NUM_CH,
   parameter int PRESC  = 1
)
(
   input  wire logic                               clk_i,
   input  wire logic                               reset_i,
   input  wire logic                               center_pwm_select_i,
   input  wire logic [tmr_evt_pkg::CNT_W-1:0]      modulo_i,
   input  wire tmr_evt_pkg::chan_cfg_t [NUM_CH-1:0] chan_cfg_i,
   input  wire logic [NUM_CH-1:0]                  chan_pin_i,
   input  wire tmr_evt_pkg::clr_req_t              ovf_clr_i,
   input  wire tmr_evt_pkg::clr_req_t [NUM_CH-1:0] chan_clr_i,
   output logic [tmr_evt_pkg::CNT_W-1:0]           count_o,
   output logic                                    counter_overflow_flag_o,
   output logic [NUM_CH-1:0]                       chan_flag_o,
   output logic [NUM_CH-1:0]                       chan_pin_oe_o
);

   localparam int PW = (PRESC > 1) ? $clog2(PRESC) : 1;

   logic [PW-1:0]                  pre_q;
   logic                           tick_w;
   logic [tmr_evt_pkg::CNT_W-1:0]  cnt_q;
   logic [tmr_evt_pkg::CNT_W-1:0]  cnt_d;
   tmr_evt_pkg::cnt_dir_t          dir_q;
   tmr_evt_pkg::cnt_dir_t          dir_d;
   logic                           at_top_w;
   logic                           at_bot_w;
   logic                           turn_w;
   logic                           wrap_w;
   logic                           ovf_q;
   logic                           ovf_armed_q;
   logic                           ovf_set_w;
   logic [NUM_CH-1:0]              flag_w;
   logic [NUM_CH-1:0]              oe_w;

   // divider makes a one-cycle count enable
   assign tick_w = (PRESC <= 1) || (pre_q == PW'(PRESC - 1));

   always_ff @(posedge clk_i)
   begin
      if (reset_i || tick_w)
         pre_q <= '0;
      else
         pre_q <= pre_q + 1'b1;
   end

   // counter next-state: up only, or up to modulo then back down in center mode
   assign at_top_w = (cnt_q >= modulo_i);
   assign at_bot_w = (cnt_q <= 16'h0001);
   assign turn_w   = tick_w && center_pwm_select_i && dir_q == tmr_evt_pkg::DIR_UP && at_top_w;
   assign wrap_w   = tick_w && !center_pwm_select_i && at_top_w;

   always_comb
   begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      if (tick_w)
      begin
         unique case (dir_q)
            tmr_evt_pkg::DIR_UP:
            begin
               if (!at_top_w)
                  cnt_d = cnt_q + 1'b1;
               else if (center_pwm_select_i)
               begin
                  cnt_d = cnt_q - 1'b1; // [RULE7]
                  dir_d = tmr_evt_pkg::DIR_DOWN;
               end
               else
                  cnt_d = tmr_evt_pkg::CNT_RESET;
            end
            tmr_evt_pkg::DIR_DOWN:
            begin
               if (!center_pwm_select_i)
               begin
                  cnt_d = tmr_evt_pkg::CNT_RESET;
                  dir_d = tmr_evt_pkg::DIR_UP;
               end
               else
               begin
                  cnt_d = cnt_q - 1'b1; // [RULE7]
                  if (at_bot_w)
                     dir_d = tmr_evt_pkg::DIR_UP;
               end
            end
            default:
            begin
               cnt_d = tmr_evt_pkg::CNT_RESET;
               dir_d = tmr_evt_pkg::DIR_UP;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         cnt_q <= tmr_evt_pkg::CNT_RESET;
         dir_q <= tmr_evt_pkg::DIR_UP;
      end
      else
      begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
      end
   end

   // overflow at turnaround in center mode, at wrap otherwise
   assign ovf_set_w = turn_w | wrap_w; // [RULE1]

   // two-step clear: read while set arms, next clear write takes effect
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         ovf_q       <= tmr_evt_pkg::FLAG_RESET;
         ovf_armed_q <= 1'b0;
      end
      else
      begin
         ovf_q <= ovf_set_w | (ovf_q & ~(ovf_clr_i.flag_clear & ovf_armed_q)); // [RULE9]
         if (ovf_clr_i.flag_clear)
            ovf_armed_q <= 1'b0;
         else if (ovf_clr_i.status_read && ovf_q)
            ovf_armed_q <= 1'b1;
      end
   end

   // channels share the counter and tick
   for (genvar i = 0; i < NUM_CH; i++)
   begin : g_ch
      chan_event u_ch
      (
         .clk_i               (clk_i),
         .reset_i             (reset_i),
         .cfg_i               (chan_cfg_i[i]),
         .center_pwm_select_i (center_pwm_select_i),
         .count_i             (cnt_q),
         .tick_i              (tick_w),
         .pin_i               (chan_pin_i[i]),
         .clr_i               (chan_clr_i[i]),
         .flag_o              (flag_w[i]),
         .pin_oe_o            (oe_w[i])
      );
   end

   assign count_o                 = cnt_q;
   assign counter_overflow_flag_o = ovf_q;
   assign chan_flag_o             = flag_w;
   assign chan_pin_oe_o           = oe_w;

   turn_ovf_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE1]
      (center_pwm_select_i && tick_w && dir_q == tmr_evt_pkg::DIR_UP && at_top_w)
      |=> ovf_q && dir_q == tmr_evt_pkg::DIR_DOWN)
      else $error("no overflow flag at turnaround");

   down_count_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE7]
      (center_pwm_select_i && tick_w && dir_q == tmr_evt_pkg::DIR_DOWN && cnt_q != 16'h0000)
      |=> cnt_q == $past(cnt_q) - 16'h0001)
      else $error("center mode counter not counting down");

   center_aligned_pwm_match_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE6]
      (center_pwm_select_i && tick_w && cnt_q == chan_cfg_i[0].value) |=> chan_flag_o[0])
      else $error("center pwm match missed");

   ovf_blind_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE9]
      (ovf_q && ovf_clr_i.flag_clear && !ovf_armed_q) |=> ovf_q)
      else $error("overflow cleared without read");

   // up-only counting: step by one below the terminal value, wrap to zero at it
   up_count_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE7]
      (!center_pwm_select_i && tick_w && dir_q == tmr_evt_pkg::DIR_UP && !at_top_w)
      |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("up counter did not step");

   up_wrap_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE7]
      (!center_pwm_select_i && tick_w && dir_q == tmr_evt_pkg::DIR_UP && at_top_w)
      |=> cnt_q == tmr_evt_pkg::CNT_RESET && ovf_q)
      else $error("up counter did not wrap");

   // leaving center mode must not strand the counter in the down direction
   up_only_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE7]
      (!center_pwm_select_i && tick_w) |=> dir_q == tmr_evt_pkg::DIR_UP)
      else $error("counter left counting down outside center mode");

   turn_up_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE7]
      (center_pwm_select_i && tick_w && dir_q == tmr_evt_pkg::DIR_DOWN && at_bot_w)
      |=> dir_q == tmr_evt_pkg::DIR_UP)
      else $error("center counter did not turn up at bottom");

   // in center mode the overflow flag may rise only at the top turnaround
   ovf_only_turn_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE1]
      (center_pwm_select_i && !turn_w && !ovf_q) |=> !ovf_q)
      else $error("overflow flag set away from turnaround");

   // sticky until an armed clear; an armed clear without a new set empties it
   ovf_hold_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE9]
      (ovf_q && !(ovf_clr_i.flag_clear && ovf_armed_q)) |=> ovf_q)
      else $error("overflow flag dropped without armed clear");

   ovf_clear_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE9]
      (ovf_armed_q && ovf_clr_i.flag_clear && !ovf_set_w) |=> !ovf_q)
      else $error("armed clear left overflow flag set");

endmodule : tmr_event_flags

// ---- bench/tb.sv ----
// self-checking bench of the timer event-flag block against a cycle model
`timescale 1ns/1ps
module tb;
   localparam int NCH = tmr_evt_pkg::NUM_CH;
   logic                            clk_i = 1'b0;
   logic                            reset_i = 1'b1;
   logic                            center_pwm_select_i = 1'b0;
   logic [15:0]                     modulo_i = 16'h0010;
   tmr_evt_pkg::chan_cfg_t [NCH-1:0] chan_cfg_i = '0;
   logic [NCH-1:0]                  chan_pin_i = '0;
   tmr_evt_pkg::clr_req_t           ovf_clr_i = '0;
   tmr_evt_pkg::clr_req_t [NCH-1:0] chan_clr_i = '0;
   logic [15:0]                     count_o;
   logic                            counter_overflow_flag_o;
   logic [NCH-1:0]                  chan_flag_o;
   logic [NCH-1:0]                  chan_pin_oe_o;
   logic [15:0]                     m_cnt;
   logic                            m_down, m_ovf, m_ovf_arm;
   logic [NCH-1:0]                  m_flag, m_arm, m_prev, m_oe;
   int                              err_count = 0;
   int                              total_checks = 0;
   int unsigned                     rng = 85;
   bit                              stim_on = 0;
   bit                              chk_on = 0;
   tmr_evt_pkg::chan_mode_t         modes [4] = '{tmr_evt_pkg::MODE_OFF,
      tmr_evt_pkg::MODE_CAPTURE, tmr_evt_pkg::MODE_COMPARE, tmr_evt_pkg::MODE_EDGE_ALIGNED_PWM};

   always #4 clk_i = ~clk_i;

   tmr_event_flags #(.NUM_CH(NCH), .PRESC(1)) u_tmr_event_flags (
      .clk_i(clk_i), .reset_i(reset_i), .center_pwm_select_i(center_pwm_select_i),
      .modulo_i(modulo_i), .chan_cfg_i(chan_cfg_i), .chan_pin_i(chan_pin_i),
      .ovf_clr_i(ovf_clr_i), .chan_clr_i(chan_clr_i), .count_o(count_o),
      .counter_overflow_flag_o(counter_overflow_flag_o), .chan_flag_o(chan_flag_o),
      .chan_pin_oe_o(chan_pin_oe_o));

   // repeatable pseudo-random source
   function automatic int unsigned xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xs

   // channel event for one cycle; center mode uses the match in both directions
   function automatic logic chan_hit(tmr_evt_pkg::chan_cfg_t c, logic ctr, logic [15:0] cnt,
                                     logic pin, logic prev);
      logic match;
      match = (cnt == c.value);
      if (ctr)
         return match;
      case (c.mode)
         tmr_evt_pkg::MODE_CAPTURE: return (c.channel_edge_select[0] & pin & ~prev)
                                          | (c.channel_edge_select[1] & ~pin & prev);
         tmr_evt_pkg::MODE_COMPARE, tmr_evt_pkg::MODE_EDGE_ALIGNED_PWM: return match;
         default: return 1'b0;
      endcase
   endfunction : chan_hit

   // sticky flag: a set in the same cycle beats an armed clear
   function automatic logic flag_next(logic f, logic arm, logic set, tmr_evt_pkg::clr_req_t r);
      return set | (f & ~(r.flag_clear & arm));
   endfunction : flag_next

   // any clear write disarms, so a clear without a fresh read is ignored
   function automatic logic arm_next(logic f, logic arm, tmr_evt_pkg::clr_req_t r);
      return r.flag_clear ? 1'b0 : (arm | (r.status_read & f));
   endfunction : arm_next

   // reference model, stepped on the same edge as the design
   always @(posedge clk_i)
   begin
      m_prev <= chan_pin_i;
      if (reset_i)
      begin
         {m_cnt, m_down, m_ovf, m_ovf_arm} <= '0;
         {m_flag, m_arm, m_oe} <= '0;
      end
      else
      begin
         if (!center_pwm_select_i)
            m_cnt <= (m_cnt == modulo_i) ? 16'h0000 : m_cnt + 16'h0001;
         else if (!m_down)
            m_cnt <= (m_cnt == modulo_i) ? m_cnt - 16'h0001 : m_cnt + 16'h0001;
         else
            m_cnt <= (m_cnt == 16'h0000) ? 16'h0001 : m_cnt - 16'h0001;
         if (center_pwm_select_i)
            m_down <= m_down ? (m_cnt != 16'h0000) : (m_cnt == modulo_i);
         m_ovf <= flag_next(m_ovf, m_ovf_arm, (m_cnt == modulo_i) && !m_down, ovf_clr_i);
         m_ovf_arm <= arm_next(m_ovf, m_ovf_arm, ovf_clr_i);
         for (int i = 0; i < NCH; i++)
         begin
            m_flag[i] <= flag_next(m_flag[i], m_arm[i], chan_hit(chan_cfg_i[i],
                         center_pwm_select_i, m_cnt, chan_pin_i[i], m_prev[i]), chan_clr_i[i]);
            m_arm[i] <= arm_next(m_flag[i], m_arm[i], chan_clr_i[i]);
            m_oe[i] <= center_pwm_select_i | (chan_cfg_i[i].mode == tmr_evt_pkg::MODE_COMPARE)
                       | (chan_cfg_i[i].mode == tmr_evt_pkg::MODE_EDGE_ALIGNED_PWM);
         end
      end
   end

   // random pins and read or clear pulses, never both in one cycle
   always @(posedge clk_i)
   begin
      if (stim_on)
      begin
         int unsigned r;
         r = xs();
         chan_pin_i <= chan_pin_i ^ (r[NCH+11:12] & r[NCH+15:16]);
         ovf_clr_i <= (r[2:0] == 3'h1) ? 2'h2 : (r[2:0] == 3'h2) ? 2'h1 : 2'h0;
         for (int i = 0; i < NCH; i++)
            chan_clr_i[i] <= (r[3*i+5 -: 3] == 3'h1) ? 2'h2
                           : (r[3*i+5 -: 3] == 3'h2) ? 2'h1 : 2'h0;
      end
   end

   task automatic chk1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s exp %b got %b", what, exp, got);
      end
   endtask : chk1

   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk16

   // compare once the edge's updates have landed
   always @(posedge clk_i)
   begin
      #1;
      if (chk_on)
      begin
         chk16("count", m_cnt, count_o);
         chk1("overflow flag", m_ovf, counter_overflow_flag_o);
         for (int i = 0; i < NCH; i++)
         begin
            chk1("channel flag", m_flag[i], chan_flag_o[i]);
            chk1("pin enable", m_oe[i], chan_pin_oe_o[i]);
         end
      end
   end

   task automatic report_and_stop();
      if (err_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   // segments: every mode and edge select on channel 0, the last ones center mode
   initial
   begin
      for (int s = 0; s < 20; s++)
      begin
         stim_on <= 1'b0;
         @(posedge clk_i);
         reset_i <= 1'b1;
         chan_pin_i <= '0;
         ovf_clr_i <= '0;
         chan_clr_i <= '0;
         center_pwm_select_i <= (s >= 16);
         modulo_i <= (s == 0) ? 16'h0002 : 16'h0002 + 16'(xs() % 40);
         @(posedge clk_i);
         chan_cfg_i[0] <= '{mode: modes[s % 4],
            channel_edge_select: tmr_evt_pkg::edge_sel_t'(2'(s / 4)),
            value: (s % 3 == 0) ? modulo_i : (s % 3 == 1) ? 16'h0000 : 16'(xs() % modulo_i)};
         chan_cfg_i[1] <= '{mode: modes[xs() % 4],
            channel_edge_select: tmr_evt_pkg::edge_sel_t'(2'(xs())),
            value: 16'(xs() % (modulo_i + 16'h0001))};
         repeat (3) @(posedge clk_i);
         reset_i <= 1'b0;
         stim_on <= 1'b1;
         chk_on <= 1'b1;
         repeat (300) @(posedge clk_i);
      end
      report_and_stop();
   end

   // watchdog well beyond the expected run of about 6100 cycles
   initial
   begin
      #100000;
      err_count++;
      report_and_stop();
   end
endmodule : tb
